//--- core/lpm_params.svh
// Purpose: Named offsets, field positions, reset values and counts of the pin mux
// Assumes: Included by bare name from the package only; the design files use its macros
// Notes: Register indices are word indices; the byte address is four times the index
//
// Operation
// R1: Port-9 function-select register picks GPIO or alternate function per port-9 pin.
// R2: Port-9 bit-4 pin drives the RTC second pulse when selected.
// R3: In calibration, seconds 1-29 pass raw pulses; second 30 passes corrected pulse.
// R4: Port-9 bit-3 pin drives divided-PLL pulse, optionally the one-second PLL pulse.
// R5: A dedicated pin always carries the first energy path pulse.
// R6: Port 3 bits 0-3 are GPIO after reset, switchable to LCD backplanes.
// R7: Port 4 bits 0-1: segments at LCD type zero, backplanes at types 1-3.
// R8: Port 5 bits 0-1: segments at LCD type 0-1, backplanes at types 2-3.
// R9: Port 4 bit 2 to port 8 bit 2 become segments when enable bit set.
// R10: Port-9 bit-0 pin is GPIO, bidirectional timer port zero, or segment.
// R11: Three highest segment pins feed aux measurement; upper two feed aux comparator.
// R12: Software disables segment drive on an analog pin before using it analog.
// R13: Segment-capable pins without explicit select are GPIO until segment enabled; segments 36-39 have no GPIO stage and float instead.
// R14: Exactly one function drives each pin; LCD type beats segment enables.
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ****************************************
// Register map (word indices)
// ****************************************
`define LPM_IDX_FUNC_SEL 14'h00ad
`define LPM_IDX_LCD_CTRL 14'h2c1e
`define LPM_IDX_SEG_EN0 14'h2c20
`define LPM_SEG_EN_REGS 14'h0005
`define LPM_IDX_PIN_CFG 14'h2c28
`define LPM_IDX_STATUS 14'h2c29
`define LPM_RST_BYTE 8'h00
`define LPM_RST_SEG_EN 40'h00_0000_0000

// ****************************************
// Field positions
// ****************************************
`define LPM_LCD_TYPE_HI 5
`define LPM_LCD_TYPE_LO 4
`define LPM_FS_TIMER_BIT 0
`define LPM_FS_PLL_BIT 3
`define LPM_FS_PPS_BIT 4
`define LPM_CFG_COM_BIT 0
`define LPM_CFG_PLL1S_BIT 1
`define LPM_CFG_CAL_BIT 2
`define LPM_TYPE_SEG_ONLY 2'h0
`define LPM_TYPE_FOUR_COM 2'h1
`define LPM_TYPE_SIX_COM 2'h2

// ****************************************
// Counts and pad layout
// ****************************************
`define LPM_SEC_FIRST 5'h00
`define LPM_SEC_LAST 5'h1d
`define LPM_SEC_STEP 5'h01
`define LPM_NUM_PADS 46
`define LPM_NUM_SEG 40
`define LPM_NUM_COM 8
`define LPM_PAD_SEG 4
`define LPM_PAD_PLL 44
`define LPM_PAD_PPS 45
`define LPM_SEG_TIMER 35
`define LPM_SEG_OUT_ONLY 36
`define LPM_SEG_ANALOG 37
`define LPM_COM_P4 4
`define LPM_COM_P5 6
`define LPM_SEG_P5 8

`endif

//--- core/lpm_pkg.sv
// Purpose: Types shared by the pin mux files
// Assumes: lpm_params.svh holds all numeric constants
// Notes: Types only
package lpm_pkg;
  `include "lpm_params.svh"

  // Function driving one pad
  typedef enum logic [1:0] {
    LPM_FN_GPIO,
    LPM_FN_SEG,
    LPM_FN_COM,
    LPM_FN_ALT
  } lpm_fn_t;

  // Drive of one pin: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } lpm_drv_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } lpm_apb_req_t;
endpackage

//--- core/lpm_pad_cell.sv
// Purpose: One pad output stage choosing exactly one driving function
// Assumes: Select and sources are steady relative to clk_i
// Notes: Output is registered so pad drive never glitches during a select change
`timescale 1ns/100ps
module lpm_pad_cell import lpm_pkg::*; #(
  parameter bit HAS_GPIO = 1'b1
) (
  input wire clk_i,
  input wire rstn_i,
  input wire lpm_fn_t sel_i,
  input wire lpm_drv_t gpio_i,
  input wire seg_i,
  input wire com_i,
  input wire lpm_drv_t alt_i,
  output lpm_drv_t pad_o
);
  lpm_drv_t next_pad;

  // ****************************************
  // Source selection
  // ****************************************
  // One case arm per function, so two sources can never share the pin
  always_comb begin
    case (sel_i)
      LPM_FN_GPIO: next_pad = HAS_GPIO ? gpio_i : '0; // R13
      LPM_FN_SEG: next_pad = '{out: seg_i, oe: 1'b1};
      LPM_FN_COM: next_pad = '{out: com_i, oe: 1'b1};
      LPM_FN_ALT: next_pad = alt_i;
      default: next_pad = '0;
    endcase
  end

  // Pad register; released pin after reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_o <= '0;
    end else begin
      pad_o <= next_pad; // R14
    end
  end
endmodule

//--- core/lpm_pin_mux.sv
// Purpose: Pin function mux for the LCD and port-9 pin group, with APB registers
// Assumes: All inputs synchronous to clk_i; APB with zero wait states
// Notes: Pad index 0-3 port 3, 4-43 segments 0-39, 44 PLL pin, 45 second pin
`timescale 1ns/100ps
module lpm_pin_mux import lpm_pkg::*; (
  input wire clk_i,
  input wire rstn_i,
  input wire lpm_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire lpm_drv_t [`LPM_NUM_PADS-1:0] gpio_drv_i,
  output logic [`LPM_NUM_PADS-1:0] gpio_in_o,
  input wire [`LPM_NUM_PADS-1:0] pad_in_i,
  output lpm_drv_t [`LPM_NUM_PADS-1:0] pad_o,
  input wire [`LPM_NUM_SEG-1:0] lcd_seg_i,
  input wire [`LPM_NUM_COM-1:0] lcd_com_i,
  output logic [1:0] lcd_type_o,
  output logic [`LPM_NUM_SEG-1:0] seg_enable_o,
  input wire rtc_pulse_i,
  input wire rtc_cal_pulse_i,
  input wire pll_div_pulse_i,
  input wire pll_sec_pulse_i,
  input wire lpm_drv_t timer_a_drv_i,
  output logic timer_a_in_o,
  input wire energy_pulse_one_i,
  output logic energy_pulse_one_o,
  input wire [2:0] aux_analog_req_i,
  output logic [2:0] aux_meas_connect_o,
  output logic [1:0] aux_cmp_connect_o
);
  logic [7:0] port9_function_select;
  logic [7:0] lcd_control;
  logic [7:0] pin_config;
  logic [`LPM_NUM_SEG-1:0] seg_en;
  logic [4:0] sec_cnt;
  logic rtc_pulse_q;

  // ****************************************
  // APB decode
  // ****************************************
  // Single-cycle access; read data is latched in the setup cycle
  wire [13:0] idx = apb_i.paddr[15:2];
  wire [13:0] seg_off = idx - `LPM_IDX_SEG_EN0;
  wire hit_fs = idx == `LPM_IDX_FUNC_SEL;
  wire hit_lcd = idx == `LPM_IDX_LCD_CTRL;
  wire hit_seg = seg_off < `LPM_SEG_EN_REGS;
  wire hit_cfg = idx == `LPM_IDX_PIN_CFG;
  wire hit_sts = idx == `LPM_IDX_STATUS;
  wire addr_hit = hit_fs | hit_lcd | hit_seg | hit_cfg | hit_sts;
  wire setup_rd = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;
  wire access_wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  wire [7:0] wbyte = apb_i.pwdata[7:0];
  wire [2:0] seg_byte = seg_off[2:0];
  wire [2:0] analog_clash = aux_analog_req_i & seg_en[`LPM_NUM_SEG-1:`LPM_SEG_ANALOG];
  wire [7:0] status_byte = {analog_clash, sec_cnt};
  wire [7:0] seg_rd = seg_en[{seg_byte, 3'h0} +: 8];
  wire [7:0] rd_byte = hit_fs ? port9_function_select :
                       hit_lcd ? lcd_control :
                       hit_seg ? seg_rd :
                       hit_cfg ? pin_config :
                       hit_sts ? status_byte : `LPM_RST_BYTE;

  // Handshake: always ready, error on an unmapped address
  assign pready_o = 1'b1;
  assign pslverr_o = apb_i.psel & apb_i.penable & ~addr_hit;

  // Read data register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= '0;
    end else if (setup_rd) begin
      prdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Writes land at the access edge; status is read only and ignores writes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port9_function_select <= `LPM_RST_BYTE;
      lcd_control <= `LPM_RST_BYTE;
      pin_config <= `LPM_RST_BYTE;
    end else if (access_wr) begin
      if (hit_fs) port9_function_select <= wbyte; // R1
      if (hit_lcd) lcd_control <= wbyte; // R7
      if (hit_cfg) pin_config <= wbyte;
    end
  end

  // Segment enables, one byte lane per register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seg_en <= `LPM_RST_SEG_EN;
    end else if (access_wr && hit_seg) begin
      seg_en[{seg_byte, 3'h0} +: 8] <= wbyte; // R9
    end
  end

  wire [1:0] lcd_type = lcd_control[`LPM_LCD_TYPE_HI:`LPM_LCD_TYPE_LO];
  wire fs_timer = port9_function_select[`LPM_FS_TIMER_BIT];
  wire fs_pll = port9_function_select[`LPM_FS_PLL_BIT];
  wire fs_pps = port9_function_select[`LPM_FS_PPS_BIT];
  wire com_en = pin_config[`LPM_CFG_COM_BIT];
  wire pll_1s = pin_config[`LPM_CFG_PLL1S_BIT];
  wire cal_en = pin_config[`LPM_CFG_CAL_BIT];
  assign lcd_type_o = lcd_type;
  assign seg_enable_o = seg_en;

  // ****************************************
  // Second pulse and calibration cycle
  // ****************************************
  // Counter sits at the last second while idle so a new cycle starts at second one
  wire rtc_rise = rtc_pulse_i & ~rtc_pulse_q;
  wire [4:0] sec_inc = (sec_cnt == `LPM_SEC_LAST) ? `LPM_SEC_FIRST : sec_cnt + `LPM_SEC_STEP;
  wire [4:0] next_sec = !cal_en ? `LPM_SEC_LAST : rtc_rise ? sec_inc : sec_cnt;
  // Look ahead at the rising edge so the thirtieth pulse is corrected from its first cycle
  wire last_sec = cal_en && ((rtc_rise ? sec_inc : sec_cnt) == `LPM_SEC_LAST);
  wire pps_src = last_sec ? rtc_cal_pulse_i : rtc_pulse_i; // R3
  wire pll_src = pll_1s ? pll_sec_pulse_i : pll_div_pulse_i; // R4

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_cnt <= `LPM_SEC_LAST;
      rtc_pulse_q <= 1'b0;
    end else begin
      sec_cnt <= next_sec; // R3
      rtc_pulse_q <= rtc_pulse_i;
    end
  end

  // ****************************************
  // Per-pad select and sources
  // ****************************************
  lpm_fn_t [`LPM_NUM_PADS-1:0] pad_sel;
  logic [`LPM_NUM_PADS-1:0] pad_seg;
  logic [`LPM_NUM_PADS-1:0] pad_com;
  lpm_drv_t [`LPM_NUM_PADS-1:0] pad_alt;

  // Port 3 backplanes on a single switch
  genvar gi;
  generate
    for (gi = 0; gi < `LPM_PAD_SEG; gi++) begin : g_p3
      assign pad_sel[gi] = com_en ? LPM_FN_COM : LPM_FN_GPIO; // R6
      assign pad_seg[gi] = 1'b0;
      assign pad_com[gi] = lcd_com_i[gi];
      assign pad_alt[gi] = '0;
    end
    // Segment pins; LCD type is decided before the per-pin enable
    for (gi = 0; gi < `LPM_NUM_SEG; gi++) begin : g_seg
      localparam int P = gi + `LPM_PAD_SEG;
      wire lpm_fn_t own = seg_en[gi] ? LPM_FN_SEG : LPM_FN_GPIO; // R13
      assign pad_seg[P] = lcd_seg_i[gi];
      if (gi < `LPM_COM_P5 - `LPM_COM_P4) begin : g_p4
        assign pad_sel[P] = (lcd_type != `LPM_TYPE_SEG_ONLY) ? LPM_FN_COM : own; // R7 R14
        assign pad_com[P] = lcd_com_i[gi + `LPM_COM_P4];
      end else if (gi == `LPM_SEG_P5 || gi == `LPM_SEG_P5 + 1) begin : g_p5
        assign pad_sel[P] = (lcd_type >= `LPM_TYPE_SIX_COM) ? LPM_FN_COM : own; // R8 R14
        assign pad_com[P] = lcd_com_i[gi - `LPM_SEG_P5 + `LPM_COM_P5];
      end else if (gi == `LPM_SEG_TIMER) begin : g_tmr
        assign pad_sel[P] = fs_timer ? LPM_FN_ALT : own; // R10
        assign pad_com[P] = 1'b0;
      end else begin : g_plain
        assign pad_sel[P] = own; // R9
        assign pad_com[P] = 1'b0;
      end
      if (gi == `LPM_SEG_TIMER) begin : g_talt
        assign pad_alt[P] = timer_a_drv_i; // R10
      end else begin : g_nalt
        assign pad_alt[P] = '0;
      end
    end
  endgenerate

  // Port-9 pulse pins
  assign pad_sel[`LPM_PAD_PLL] = fs_pll ? LPM_FN_ALT : LPM_FN_GPIO; // R1 R4
  assign pad_sel[`LPM_PAD_PPS] = fs_pps ? LPM_FN_ALT : LPM_FN_GPIO; // R1 R2
  assign pad_seg[`LPM_PAD_PPS:`LPM_PAD_PLL] = 2'h0;
  assign pad_com[`LPM_PAD_PPS:`LPM_PAD_PLL] = 2'h0;
  assign pad_alt[`LPM_PAD_PLL] = '{out: pll_src, oe: 1'b1}; // R4
  assign pad_alt[`LPM_PAD_PPS] = '{out: pps_src, oe: 1'b1}; // R2

  // ****************************************
  // Pad cells
  // ****************************************
  // The top segment pins have no GPIO stage and float when not driving segments
  generate
    for (gi = 0; gi < `LPM_NUM_PADS; gi++) begin : g_cell
      localparam bit GP = !(gi >= `LPM_PAD_SEG + `LPM_SEG_OUT_ONLY && gi < `LPM_PAD_PLL);
      lpm_pad_cell #(.HAS_GPIO(GP)) u_cell (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .sel_i(pad_sel[gi]),
        .gpio_i(gpio_drv_i[gi]),
        .seg_i(pad_seg[gi]),
        .com_i(pad_com[gi]),
        .alt_i(pad_alt[gi]),
        .pad_o(pad_o[gi])
      );
    end
  endgenerate

  // ****************************************
  // Inputs, energy pulse and analog switches
  // ****************************************
  // Analog switch closes only with segment drive off, guarding the glass from the input
  wire [2:0] meas_ok = aux_analog_req_i & ~seg_en[`LPM_NUM_SEG-1:`LPM_SEG_ANALOG];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gpio_in_o <= '0;
      timer_a_in_o <= 1'b0;
      energy_pulse_one_o <= 1'b0;
      aux_meas_connect_o <= 3'h0;
      aux_cmp_connect_o <= 2'h0;
    end else begin
      gpio_in_o <= pad_in_i;
      timer_a_in_o <= pad_in_i[`LPM_PAD_SEG + `LPM_SEG_TIMER]; // R10
      energy_pulse_one_o <= energy_pulse_one_i; // R5
      aux_meas_connect_o <= meas_ok; // R11 R12
      aux_cmp_connect_o <= meas_ok[2:1]; // R11
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence wr_lcd_s;
    access_wr && hit_lcd;
  endsequence
  sequence wr_fs_s;
    access_wr && hit_fs;
  endsequence
  // Read setup on a mapped register, and any access phase
  sequence rd_setup_s;
    setup_rd && addr_hit;
  endsequence
  sequence acc_s;
    apb_i.psel && apb_i.penable;
  endsequence

  // Bus answer: data latched at setup, error only for unmapped words
  rd_data_lat_a: assert property (rd_setup_s |=> prdata_o == {24'h00_0000, $past(rd_byte)}) // R1
    else $error("read data not latched");
  unmapped_err_a: assert property (acc_s && !addr_hit |-> pslverr_o) // R1
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc_s && addr_hit |-> !pslverr_o) // R1
    else $error("mapped access flagged");
  lcd_write_takes_a: assert property (wr_lcd_s |=> lcd_control == $past(wbyte)) // R7
    else $error("lcd control write lost");
  // Pin routes that the list below does not already watch
  p4_seg_type_a: assert property (lcd_type == 2'h0 && seg_en[0] |=> pad_o[4] == {$past(lcd_seg_i[0]), 1'b1}) // R7
    else $error("port 4 segment missing");
  no_gpio_float_a: assert property (!seg_en[36] |=> !pad_o[40].oe) // R13
    else $error("output only pin driven");
  pll_div_mode_a: assert property (fs_pll && !pll_1s |=> pad_o[44] == {$past(pll_div_pulse_i), 1'b1}) // R4
    else $error("pll pin not divided pulse");
  pps_gpio_a: assert property (!fs_pps |=> pad_o[45] == $past(gpio_drv_i[45])) // R1
    else $error("second pin left gpio");
  cal_count_hold_a: assert property (!cal_en |=> sec_cnt == `LPM_SEC_LAST) // R3
    else $error("second count not parked");
  comp_pair_a: assert property (aux_cmp_connect_o == aux_meas_connect_o[2:1]) // R11
    else $error("comparator switch differs");

  fs_write_takes_a: assert property (wr_fs_s |=> port9_function_select == $past(wbyte)) // R1
    else $error("function select write lost");
  pps_pin_route_a: assert property (fs_pps && !cal_en |=> pad_o[`LPM_PAD_PPS].out == $past(rtc_pulse_i)) // R2
    else $error("second pin not following rtc pulse");
  cal_last_sec_a: assert property (cal_en && rtc_rise && sec_cnt == 5'h1c |-> pps_src == rtc_cal_pulse_i) // R3
    else $error("thirtieth second not corrected");
  cal_count_wrap_a: assert property (cal_en && rtc_rise && sec_cnt == 5'h1d |=> sec_cnt == 5'h00) // R3
    else $error("second count did not wrap");
  pll_pin_mode_a: assert property (fs_pll && pll_1s |=> pad_o[`LPM_PAD_PLL] == {$past(pll_sec_pulse_i), 1'b1}) // R4
    else $error("pll pin wrong source");
  energy_pass_a: assert property (1'b1 |=> energy_pulse_one_o == $past(energy_pulse_one_i)) // R5
    else $error("energy pulse not passed");
  p3_backplane_a: assert property (com_en |=> pad_o[2] == {$past(lcd_com_i[2]), 1'b1}) // R6
    else $error("port 3 backplane missing");
  lcd_type_com_a: assert property (wr_lcd_s ##1 (lcd_type == 2'h1) |=> pad_o[`LPM_PAD_SEG].oe && pad_o[`LPM_PAD_SEG].out == $past(lcd_com_i[4])) // R7
    else $error("port 4 backplane missing");
  p5_seg_type_a: assert property (lcd_type == 2'h1 && seg_en[8] |=> pad_o[12] == {$past(lcd_seg_i[8]), 1'b1}) // R8
    else $error("port 5 segment missing");
  seg_enable_a: assert property (seg_en[20] |=> pad_o[24] == {$past(lcd_seg_i[20]), 1'b1}) // R9
    else $error("segment pin not driven");
  timer_port_a: assert property (fs_timer |=> pad_o[39] == $past(timer_a_drv_i)) // R10
    else $error("timer port not routed");
  analog_guard_a: assert property (seg_en[38] |=> !aux_meas_connect_o[1] && !aux_cmp_connect_o[0]) // R11
    else $error("analog switch closed with segment drive");
  gpio_default_a: assert property (!seg_en[5] && lcd_type == 2'h0 |=> pad_o[9] == $past(gpio_drv_i[9])) // R13
    else $error("segment pin left gpio");
  type_precedence_a: assert property (lcd_type == 2'h3 |=> pad_o[13].out == $past(lcd_com_i[7])) // R14
    else $error("lcd type did not win");
endmodule

//--- sim/lpm_far_side.sv
// Purpose: Far side of the pin mux: LCD waveforms, second and PLL pulses, timer port
// Assumes: One clock; every output moves just after a rising edge
// Notes: Patterns change each cycle; a stale pad value is seen when its tick bit toggles, a swapped one only if the two waveforms differ
`timescale 1ns/100ps
module lpm_far_side import lpm_pkg::*; #(
  parameter int SEC_CYCLES = 8
) (
  input wire clk_i,
  input wire rstn_i,
  output logic [`LPM_NUM_SEG-1:0] seg_o,
  output logic [`LPM_NUM_COM-1:0] com_o,
  output logic rtc_o,
  output logic cal_o,
  output logic pll_div_o,
  output logic pll_sec_o,
  output lpm_drv_t timer_o,
  output logic energy_o
);
  // ****************************************
  // Pattern source
  // ****************************************
  logic [7:0] tick;

  // LCD waveforms run free, so there is no idle level to hold
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end

  // Each backplane gets its own tick bit; segments reuse the eight tick bits under a per-byte XOR mask
  assign seg_o = {5{tick}} ^ 40'h01_23_45_67_89;
  assign com_o = ~tick ^ 8'h3c;
  // Raw and corrected pulses sit half a second apart so they never overlap
  assign rtc_o = (int'(tick) % SEC_CYCLES) == 0;
  assign cal_o = (int'(tick) % SEC_CYCLES) == SEC_CYCLES / 2;
  assign pll_div_o = tick[0];
  assign pll_sec_o = tick[2] & ~tick[1];
  assign timer_o = '{out: tick[1] ^ tick[3], oe: tick[2]};
  assign energy_o = tick[3] ^ tick[0];
endmodule

//--- sim/lpm_pin_mux_tb.sv
// Purpose: Self-checking bench for the pin mux
// Assumes: APB answers with zero wait states; pads lag their source by one edge
// Notes: Expected pad values come from copies of the sources taken at each edge
`timescale 1ns/100ps
module lpm_pin_mux_tb import lpm_pkg::*;;
  localparam int SEC = 8;
  logic clk_i, rstn_i, pready, pslverr, rerr;
  lpm_apb_req_t apb;
  logic [31:0] prdata, rdat;
  logic [91:0] gbits;
  lpm_drv_t [`LPM_NUM_PADS-1:0] gdrv, pads, p_gdrv;
  logic [`LPM_NUM_PADS-1:0] gin, pin, p_pin;
  logic [39:0] lcd_segment_line, seg_en, p_seg;
  logic [7:0] com, p_com;
  logic [1:0] ltype, acmp;
  logic [2:0] areq, meas;
  logic rtc, cal, pdiv, psec, en_i, en_o, tin, p_rtc, p_cal, p_pdiv, p_psec, p_en;
  lpm_drv_t tmr, p_tmr;
  int n_mismatch, checked;

  lpm_pin_mux uut (.clk_i(clk_i), .rstn_i(rstn_i), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .gpio_drv_i(gdrv), .gpio_in_o(gin),
    .pad_in_i(pin), .pad_o(pads), .lcd_seg_i(lcd_segment_line), .lcd_com_i(com), .lcd_type_o(ltype),
    .seg_enable_o(seg_en), .rtc_pulse_i(rtc), .rtc_cal_pulse_i(cal), .pll_div_pulse_i(pdiv),
    .pll_sec_pulse_i(psec), .timer_a_drv_i(tmr), .timer_a_in_o(tin),
    .energy_pulse_one_i(en_i), .energy_pulse_one_o(en_o), .aux_analog_req_i(areq),
    .aux_meas_connect_o(meas), .aux_cmp_connect_o(acmp));
  lpm_far_side #(.SEC_CYCLES(SEC)) far (.clk_i(clk_i), .rstn_i(rstn_i), .seg_o(lcd_segment_line),
    .com_o(com), .rtc_o(rtc), .cal_o(cal), .pll_div_o(pdiv), .pll_sec_o(psec),
    .timer_o(tmr), .energy_o(en_i));

  // ****************************************
  // Clock, GPIO stimulus and source copies
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  assign gdrv = gbits;
  assign pin = ~gbits[45:0];
  // Johnson pattern keeps GPIO drive moving; copies give last edge's sources
  always @(posedge clk_i) begin
    gbits <= {gbits[90:0], ~gbits[91]};
    {p_gdrv, p_pin, p_seg, p_com, p_tmr} <= {gdrv, pin, lcd_segment_line, com, tmr};
    {p_rtc, p_cal, p_pdiv, p_psec, p_en} <= {rtc, cal, pdiv, psec, en_i};
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      apb <= '0;
    end
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [13:0] idx);
    xfer(1'b0, idx, 8'h00);
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic pad(input int p, input lpm_drv_t e);
    check(64'(pads[p]), 64'(e));
  endtask
  function automatic lpm_drv_t drv(input logic v);
    return '{out: v, oe: 1'b1};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [13:0] idx[7];
    idx = '{`LPM_IDX_FUNC_SEL, `LPM_IDX_LCD_CTRL, `LPM_IDX_PIN_CFG, `LPM_IDX_SEG_EN0,
      `LPM_IDX_SEG_EN0 + 14'h1, `LPM_IDX_SEG_EN0 + 14'h2, `LPM_IDX_SEG_EN0 + 14'h4};
    step();
    // Output-only segment pins have no GPIO, so they must float
    for (int p = 0; p < 46; p++) begin
      if (p >= 40 && p < 44) check(pads[p].oe, 1'b0);
      else pad(p, p_gdrv[p]);
    end
    check(gin, p_pin);
    check(tin, p_pin[39]);
    check(en_o, p_en);
    for (int i = 0; i < 7; i++) begin
      rd(idx[i]);
      check({rerr, rdat}, 33'h0);
    end
    rd(14'h0001);
    check({rerr, rdat}, {1'b1, 32'h0});
  endtask
  task automatic t_port3();
    wr(`LPM_IDX_PIN_CFG, 8'h01);
    step();
    for (int p = 0; p < 4; p++) pad(p, drv(p_com[p]));
    wr(`LPM_IDX_PIN_CFG, 8'h00);
    step();
    pad(2, p_gdrv[2]);
  endtask
  // Segment 1 and 9 stay disabled: only the LCD type may take them over
  task automatic t_type();
    wr(`LPM_IDX_SEG_EN0, 8'h05);
    wr(`LPM_IDX_SEG_EN0 + 14'h1, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(`LPM_IDX_LCD_CTRL, {2'b00, t[1:0], 4'h0});
      step();
      check(ltype, t[1:0]);
      pad(4, t == 0 ? drv(p_seg[0]) : drv(p_com[4]));
      pad(5, t == 0 ? p_gdrv[5] : drv(p_com[5]));
      pad(6, drv(p_seg[2]));
      pad(7, p_gdrv[7]);
      pad(12, t < 2 ? drv(p_seg[8]) : drv(p_com[6]));
      pad(13, t < 2 ? p_gdrv[13] : drv(p_com[7]));
    end
    rd(`LPM_IDX_LCD_CTRL);
    check(rdat, 32'h30);
    check(seg_en, 40'h00_0000_0105);
    wr(`LPM_IDX_LCD_CTRL, 8'h00);
    wr(`LPM_IDX_SEG_EN0, 8'h00);
    wr(`LPM_IDX_SEG_EN0 + 14'h1, 8'h00);
  endtask
  task automatic t_p9();
    wr(`LPM_IDX_SEG_EN0 + 14'h4, 8'h08);
    wr(`LPM_IDX_FUNC_SEL, 8'h19);
    for (int i = 0; i < 2 * SEC; i++) begin
      step();
      // Step off the access edge so pads and copies are both settled
      if (i == SEC) begin
        wr(`LPM_IDX_PIN_CFG, 8'h02);
        #1;
      end
      pad(39, p_tmr);
      pad(44, drv(i > SEC ? p_psec : p_pdiv));
      pad(45, drv(p_rtc));
      check(en_o, p_en);
    end
    wr(`LPM_IDX_FUNC_SEL, 8'h00);
    step();
    pad(39, drv(p_seg[35]));
    pad(44, p_gdrv[44]);
    pad(45, p_gdrv[45]);
    wr(`LPM_IDX_SEG_EN0 + 14'h4, 8'h00);
    wr(`LPM_IDX_PIN_CFG, 8'h00);
  endtask
  // Any 60 consecutive seconds hold exactly two corrected ones
  task automatic t_cal();
    int i, n_raw, n_cal;
    wr(`LPM_IDX_FUNC_SEL, 8'h10);
    wr(`LPM_IDX_PIN_CFG, 8'h04);
    i = 0;
    do begin
      step();
      i++;
    end while (rtc !== 1'b1 && i < 4 * SEC);
    if (rtc !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end else begin
      n_raw = 0;
      n_cal = 0;
      for (i = 0; i < 60 * SEC; i++) begin
        step();
        if (pads[45].out === 1'b1 && p_rtc === 1'b1) n_raw++;
        if (pads[45].out === 1'b1 && p_cal === 1'b1) n_cal++;
      end
      check(n_raw, 58);
      check(n_cal, 2);
      wr(`LPM_IDX_PIN_CFG, 8'h00);
      wr(`LPM_IDX_STATUS, 8'hff);
      rd(`LPM_IDX_STATUS);
      check(rdat, 32'h1d);
      wr(`LPM_IDX_FUNC_SEL, 8'h00);
    end
  endtask
  task automatic t_analog();
    @(posedge clk_i);
    areq <= 3'b111;
    step();
    check(meas, 3'b111);
    check(acmp, 2'b11);
    check(pads[42].oe, 1'b0);
    wr(`LPM_IDX_SEG_EN0 + 14'h4, 8'h40);
    step();
    check(meas, 3'b101);
    check(acmp, 2'b10);
    pad(42, drv(p_seg[38]));
    rd(`LPM_IDX_STATUS);
    check(rdat, 32'h5d);
  endtask

  // Reset for four cycles, then the scenarios in turn
  initial begin
    rstn_i = 1'b0;
    apb = '0;
    areq = 3'b000;
    gbits = '0;
    n_mismatch = 0;
    checked = 0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_port3();
    t_type();
    t_p9();
    t_cal();
    t_analog();
    stop_test();
  end
endmodule
